// [hdl/fpc_device.sv]
/*
 * Flash page programming control: page buffer, launch detector,
 * erase/program sequencer and code space mapping, with the flash arrays.
 * Assumes the host issues at most one strobe per cycle on pclk.
 */
`timescale 1ns/10ps
module fpc_device
    import fpc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // CPU side link
    fpc_if.dev link,
    // External data memory write steering
    output logic xram_wr,
    output logic xram_ext
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_DELAY = 3'b001,
        S_ERASE_WAIT = 3'b010,
        S_ERASE = 3'b011,
        S_PROG_WAIT = 3'b100,
        S_PROG = 3'b101
    } fpc_state_t;

    fpc_state_t state;
    logic [15:0] timer;
    logic [6:0] walk;
    fpc_region_t op_region, region, armed_region;
    logic page_map, armed, seq_err, buf_loaded;
    logic [PAGE_BYTES-1:0] loaded;
    logic [8:0] page_addr;
    logic [7:0] pbuf [PAGE_BYTES];
    logic [7:0] user_mem [65536];
    logic [7:0] extra_row_mem [PAGE_BYTES];
    logic [7:0] sec_byte;

    logic [3:0] nib;
    fpc_region_t wr_region;
    logic idle, busy, go_ok, launch_write, launch_reset, empty_err;
    logic intervene, seq_bad, op_done, success, pb_wr, mem_we;
    logic [7:0] mem_val;
    logic [7:0] next_code_rdata;
    logic [7:0] code_rdata_q;
    logic code_rvalid_q;

    assign nib = link.ctrl_wdata[CTRL_NIB_LSB +: 4];
    assign wr_region = fpc_region_t'(link.ctrl_wdata[CTRL_REGION_LSB +: 2]);
    assign idle = (state == S_IDLE);
    assign busy = !idle && (state != S_DELAY);
    // Second write must be A, armed, same region and sequencer free
    assign go_ok = link.ctrl_wr && (nib == NIB_GO) && armed && idle &&
        (wr_region == armed_region);
    assign launch_write = go_ok && (wr_region != REG_RESET) &&
        buf_loaded;
    assign launch_reset = go_ok && (wr_region == REG_RESET);
    assign empty_err = go_ok && (wr_region != REG_RESET) &&
        !buf_loaded;
    // Any other access between the two launch writes breaks the pair
    assign intervene = armed &&
        (link.stat_wr || link.dptr_wr || link.code_rd);
    assign seq_bad = (link.ctrl_wr && armed && !go_ok) ||
        (link.ctrl_wr && !armed && (nib == NIB_GO)) ||
        intervene || empty_err;
    assign op_done = (state == S_PROG) && (walk == LAST_BYTE);
    assign success = op_done || launch_reset;
    assign pb_wr = link.dptr_wr && page_map && idle;

    // Launch detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
            armed_region <= REG_USER;
        end else if (link.ctrl_wr) begin
            armed <= (nib == NIB_ARM);
            armed_region <= wr_region;
        end else if (intervene) begin
            armed <= 1'b0;
        end
    end

    // Writable control fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_map <= 1'b0;
            region <= REG_USER;
        end else if (link.ctrl_wr) begin
            page_map <= link.ctrl_wdata[CTRL_MAP_BIT];
            region <= wr_region;
        end
    end

    // Sequence error: a new error wins over any clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_err <= 1'b0;
        end else if (seq_bad) begin
            seq_err <= 1'b1;
        end else if (success) begin
            seq_err <= 1'b0;
        end else if (link.stat_wr && !link.stat_wdata[STAT_SEQUENCE_ERROR_BIT]) begin
            seq_err <= 1'b0;
        end
    end

    // Buffer occupancy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_loaded <= 1'b0;
            loaded <= '0;
            page_addr <= 9'h000;
        end else if (success) begin
            buf_loaded <= 1'b0;
            loaded <= '0;
        end else if (pb_wr) begin
            buf_loaded <= 1'b1;
            loaded[link.dptr_addr[6:0]] <= 1'b1;
            page_addr <= link.dptr_addr[15:7];
        end
    end

    // Buffer data; unloaded entries are never used, so no reset needed
    always_ff @(posedge pclk) begin
        if (pb_wr) begin
            pbuf[link.dptr_addr[6:0]] <= link.dptr_data;
        end
    end

    // Steering of pointer writes made while the page map is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xram_wr <= 1'b0;
            xram_ext <= 1'b0;
        end else begin
            xram_wr <= link.dptr_wr && !page_map;
            if (link.dptr_wr && !page_map) begin
                xram_ext <= link.external_data_select;
            end
        end
    end

    // Erase then program sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            timer <= 16'h0000;
            walk <= 7'h00;
            op_region <= REG_USER;
        end else begin
            unique case (state)
                S_IDLE: begin
                    timer <= 16'h0000;
                    walk <= 7'h00;
                    if (launch_write) begin
                        op_region <= wr_region;
                        state <= S_DELAY;
                    end
                end
                S_DELAY: begin
                    // Busy rises one machine cycle after the A write
                    if (timer == MC_CLKS - 16'h0001) begin
                        timer <= 16'h0000;
                        state <= S_ERASE_WAIT;
                    end else begin
                        timer <= timer + 16'h0001;
                    end
                end
                S_ERASE_WAIT: begin
                    if (timer == ERASE_CYCLES - 16'h0001) begin
                        timer <= 16'h0000;
                        state <= S_ERASE;
                    end else begin
                        timer <= timer + 16'h0001;
                    end
                end
                S_ERASE: begin
                    walk <= walk + 7'h01;
                    if (walk == LAST_BYTE) begin
                        state <= S_PROG_WAIT;
                    end
                end
                S_PROG_WAIT: begin
                    if (timer == PROG_CYCLES - 16'h0001) begin
                        timer <= 16'h0000;
                        state <= S_PROG;
                    end else begin
                        timer <= timer + 16'h0001;
                    end
                end
                S_PROG: begin
                    walk <= walk + 7'h01;
                    if (walk == LAST_BYTE) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Only bytes loaded into the buffer are erased and then written
    assign mem_we = ((state == S_ERASE) || (state == S_PROG)) &&
        loaded[walk];
    assign mem_val = (state == S_ERASE) ? ERASED_BYTE : pbuf[walk];

    // Flash arrays start erased
    initial begin
        for (int i = 0; i < 65536; i++) begin
            user_mem[i] = ERASED_BYTE;
        end
        for (int i = 0; i < PAGE_BYTES; i++) begin
            extra_row_mem[i] = ERASED_BYTE;
        end
        sec_byte = ERASED_BYTE;
    end

    always @(posedge pclk) begin
        if (mem_we) begin
            unique case (op_region)
                REG_USER: user_mem[{page_addr, walk}] <= mem_val;
                REG_EXTRA_ROW: extra_row_mem[walk] <= mem_val;
                REG_SEC: begin
                    if (walk == SEC_ADDR[6:0]) begin
                        sec_byte <= mem_val;
                    end
                end
                REG_RESET: begin
                end
            endcase
        end
    end

    // Code space read mapping
    always_comb begin
        next_code_rdata = user_mem[link.code_addr];
        if (link.boot_map_enable && (link.code_addr >= BOOT_BASE)) begin
            next_code_rdata = ERASED_BYTE;
        end else if ((region == REG_EXTRA_ROW) &&
            (link.code_addr >= EXTRA_ROW_BASE)) begin
            next_code_rdata = extra_row_mem[link.code_addr[6:0]];
        end else if ((region == REG_SEC) && (link.code_addr == SEC_ADDR)) begin
            next_code_rdata = sec_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_rvalid_q <= 1'b0;
            code_rdata_q <= 8'h00;
        end else begin
            code_rvalid_q <= link.code_rd;
            if (link.code_rd) begin
                code_rdata_q <= next_code_rdata;
            end
        end
    end

    assign link.code_rvalid = code_rvalid_q;
    assign link.code_rdata = code_rdata_q;
    // Launch nibble reads as zero
    assign link.ctrl_rdata = {4'h0, page_map, region, busy};
    assign link.stat_rdata = {6'h00, seq_err, buf_loaded};
endmodule : fpc_device

// [hdl/fpc_pkg.sv]
/*
 * Constants, field layouts and types shared by both ends of the flash page
 * programming link. Assumes a single 40 MHz clock for both ends.
 */
package fpc_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int MC_CLKS_I = 12;
    localparam int ERASE_TIME_NS = 2000;
    localparam int PROG_TIME_NS = 2000;
    localparam logic [15:0] MC_CLKS = 16'(MC_CLKS_I);
    localparam logic [15:0] ERASE_CYCLES =
        16'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] PROG_CYCLES =
        16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] GUARD_CYCLES = 16'(2 * MC_CLKS_I);

    // flash_control_reg fields
    localparam int CTRL_BUSY_BIT = 0;
    localparam int CTRL_REGION_LSB = 1;
    localparam int CTRL_MAP_BIT = 3;
    localparam int CTRL_NIB_LSB = 4;
    localparam logic [3:0] NIB_ARM = 4'h5;
    localparam logic [3:0] NIB_GO = 4'hA;

    // flash_status_reg fields
    localparam int STAT_LOADED_BIT = 0;
    localparam int STAT_SEQUENCE_ERROR_BIT = 1;

    // Code space map
    localparam logic [15:0] EXTRA_ROW_BASE = 16'hFF80;
    localparam logic [15:0] BOOT_BASE = 16'hF800;
    localparam logic [15:0] SEC_ADDR = 16'h0000;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int PAGE_BYTES = 128;
    localparam logic [6:0] LAST_BYTE = 7'h7F;

    // Host APB registers
    localparam logic [7:0] HOST_CMD = 8'h00;
    localparam logic [7:0] HOST_ADDR = 8'h04;
    localparam logic [7:0] HOST_STATUS = 8'h08;
    localparam logic [7:0] HOST_RDATA = 8'h0C;
    localparam logic [7:0] HOST_MODE = 8'h10;

    typedef enum logic [1:0] {
        REG_USER = 2'b00,
        REG_EXTRA_ROW = 2'b01,
        REG_SEC = 2'b10,
        REG_RESET = 2'b11
    } fpc_region_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_CTRL = 3'b001,
        OP_STAT = 3'b010,
        OP_DPTR = 3'b011,
        OP_CODE = 3'b100,
        OP_LAUNCH = 3'b101,
        OP_RSV6 = 3'b110,
        OP_RSV7 = 3'b111
    } fpc_op_t;
endpackage : fpc_pkg

// [hdl/fpc_if.sv]
/*
 * Link between the CPU-side host and the flash programming control.
 * Assumes both ends run on the same pclk.
 */
`timescale 1ns/10ps
interface fpc_if;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic stat_wr;
    logic [7:0] stat_wdata;
    logic dptr_wr;
    logic [15:0] dptr_addr;
    logic [7:0] dptr_data;
    logic code_rd;
    logic [15:0] code_addr;
    logic boot_map_enable;
    logic external_data_select;
    logic [7:0] ctrl_rdata;
    logic [7:0] stat_rdata;
    logic [7:0] code_rdata;
    logic code_rvalid;

    modport dev (
        input ctrl_wr, ctrl_wdata, stat_wr, stat_wdata,
        input dptr_wr, dptr_addr, dptr_data, code_rd, code_addr,
        input boot_map_enable, external_data_select,
        output ctrl_rdata, stat_rdata, code_rdata, code_rvalid
    );
    modport host (
        output ctrl_wr, ctrl_wdata, stat_wr, stat_wdata,
        output dptr_wr, dptr_addr, dptr_data, code_rd, code_addr,
        output boot_map_enable, external_data_select,
        input ctrl_rdata, stat_rdata, code_rdata, code_rvalid
    );
endinterface : fpc_if

// [hdl/fpc_host.sv]
/*
 * CPU-side end: takes orders from software over APB and plays them onto
 * the link as control writes, status writes, pointer writes and code reads.
 * Assumes an APB master on pclk; the slave answers with no wait states.
 */
`timescale 1ns/10ps
module fpc_host
    import fpc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to the flash control
    fpc_if.host link
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_GO = 2'b01,
        H_GUARD = 2'b10,
        H_READ = 2'b11
    } fpc_hstate_t;

    fpc_hstate_t state;
    logic [15:0] guard;
    logic [15:0] addr;
    logic [7:0] arg;
    logic [7:0] rdata;
    logic [1:0] mode;
    logic mapped;
    logic wr_acc;
    logic cmd_go;
    fpc_op_t op;
    logic [31:0] next_prdata;

    assign mapped = (paddr == HOST_CMD) || (paddr == HOST_ADDR) ||
        (paddr == HOST_STATUS) || (paddr == HOST_RDATA) ||
        (paddr == HOST_MODE);
    assign wr_acc = psel && penable && pwrite && mapped;
    assign op = fpc_op_t'(pwdata[2:0]);
    assign cmd_go = wr_acc && (paddr == HOST_CMD) && (state == H_IDLE);
    assign pready = 1'b1;
    // Unmapped, or a command while one is still running
    assign pslverr = psel && penable && (!mapped ||
        (pwrite && (paddr == HOST_CMD) && (state != H_IDLE)));

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            unique case (paddr)
                HOST_ADDR: next_prdata = {16'h0000, addr};
                HOST_STATUS: next_prdata = {8'h00, link.stat_rdata,
                    link.ctrl_rdata, 7'h00, (state != H_IDLE)};
                HOST_RDATA: next_prdata = {24'h000000, rdata};
                HOST_MODE: next_prdata = {30'h00000000, mode};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured in the setup cycle, held through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= next_prdata;
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr <= 16'h0000;
            mode <= 2'b00;
        end else if (wr_acc && (paddr == HOST_ADDR)) begin
            addr <= pwdata[15:0];
        end else if (wr_acc && (paddr == HOST_MODE)) begin
            mode <= pwdata[1:0];
        end
    end

    assign link.boot_map_enable = mode[0];
    assign link.external_data_select = mode[1];
    assign link.code_addr = addr;
    assign link.dptr_addr = addr;

    // Command sequencing and link strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= H_IDLE;
            guard <= 16'h0000;
            arg <= 8'h00;
            rdata <= 8'h00;
            link.ctrl_wr <= 1'b0;
            link.ctrl_wdata <= 8'h00;
            link.stat_wr <= 1'b0;
            link.stat_wdata <= 8'h00;
            link.dptr_wr <= 1'b0;
            link.dptr_data <= 8'h00;
            link.code_rd <= 1'b0;
        end else begin
            link.ctrl_wr <= 1'b0;
            link.stat_wr <= 1'b0;
            link.dptr_wr <= 1'b0;
            link.code_rd <= 1'b0;
            unique case (state)
                H_IDLE: begin
                    guard <= 16'h0000;
                    if (cmd_go) begin
                        arg <= pwdata[15:8];
                        unique case (op)
                            OP_CTRL: begin
                                link.ctrl_wr <= 1'b1;
                                link.ctrl_wdata <= pwdata[15:8];
                            end
                            OP_STAT: begin
                                link.stat_wr <= 1'b1;
                                link.stat_wdata <= pwdata[15:8];
                            end
                            OP_DPTR: begin
                                link.dptr_wr <= 1'b1;
                                link.dptr_data <= pwdata[15:8];
                            end
                            OP_CODE: begin
                                link.code_rd <= 1'b1;
                                state <= H_READ;
                            end
                            OP_LAUNCH: begin
                                link.ctrl_wr <= 1'b1;
                                link.ctrl_wdata <= {NIB_ARM,
                                    pwdata[11:9], 1'b0};
                                state <= H_GO;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                H_GO: begin
                    // Second write straight after, same region bits
                    link.ctrl_wr <= 1'b1;
                    link.ctrl_wdata <= {NIB_GO, arg[3:1], 1'b0};
                    state <= H_GUARD;
                end
                H_GUARD: begin
                    // Busy is not trusted until two machine cycles pass
                    if (guard == GUARD_CYCLES - 16'h0001) begin
                        state <= H_IDLE;
                    end else begin
                        guard <= guard + 16'h0001;
                    end
                end
                H_READ: begin
                    if (link.code_rvalid) begin
                        rdata <= link.code_rdata;
                        state <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : fpc_host

// [verification/fpc_asserts.sv]
/*
 * Checker on the link between host end and device end.
 * Assumes it is instantiated beside the interface, on the same clock.
 */
`timescale 1ns/10ps
module fpc_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link signals
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic stat_wr,
    input wire logic [7:0] stat_wdata,
    input wire logic dptr_wr,
    input wire logic code_rd,
    input wire logic [7:0] ctrl_rdata,
    input wire logic [7:0] stat_rdata,
    input wire logic code_rvalid
);
    logic [9:0] bcnt;
    logic armed;
    wire busy = ctrl_rdata[0];
    wire go = ctrl_wr && ctrl_wdata[7:4] == 4'hA;
    wire strobe = ctrl_wr || stat_wr || dptr_wr || code_rd;
    // Cycles that busy has stood high so far
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) bcnt <= 10'h0;
        else bcnt <= busy ? bcnt + 10'h1 : 10'h0;
    // Last strobe on the link was an arming write
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) armed <= 1'h0;
        else if (strobe) armed <= ctrl_wr && ctrl_wdata[7:4] == 4'h5;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_read_latency: assert property (code_rvalid == $past(code_rd))
        else $error("code read answer off time");
    chk_busy_start: assert property ($rose(busy) |->
        $past(go, 13) || $past(go, 14)) else $error("busy rose late");
    chk_busy_length: assert property ($fell(busy) |->
        bcnt == 10'h1A0) else $error("busy length wrong");
    chk_busy_end: assert property ($fell(busy) |->
        stat_rdata[1:0] == 2'h0) else $error("flags not cleared at end");
    chk_load_flag: assert property (dptr_wr && ctrl_rdata[3] && !busy
        && !armed |=> stat_rdata[0]) else $error("loaded flag not set");
    chk_empty_launch: assert property (go && armed && !busy
        && ctrl_wdata[2:1] != 2'h3 && !stat_rdata[0] |=> stat_rdata[1])
        else $error("empty launch not flagged");
    chk_reset_launch: assert property (go && armed && !busy
        && ctrl_rdata[2:1] == 2'h3 && ctrl_wdata[2:1] == 2'h3
        |=> stat_rdata[1:0] == 2'h0) else $error("buffer reset failed");
    chk_disarm_error: assert property (armed && (stat_wr || dptr_wr
        || code_rd) |=> stat_rdata[1]) else $error("broken pair not flagged");
    chk_error_clear: assert property (stat_wr && !stat_wdata[1]
        && !armed |=> !stat_rdata[1]) else $error("error not cleared");
    cover property (go && armed);
    cover property ($fell(busy));
    cover property (armed && dptr_wr);
endmodule : fpc_asserts

// [verification/fpc_tb.sv]
/*
 * Testbench: drives the host end over APB, device end on the link.
 * Assumes both ends share pclk and presetn.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module fpc_tb
    import fpc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic xram_wr, xram_ext;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int num_errors = 0, n_checks = 0, xw = 0;
    fpc_if link();
    fpc_device u_fpc_device(.pclk(pclk), .presetn(presetn), .link(link),
        .xram_wr(xram_wr), .xram_ext(xram_ext));
    fpc_host u_fpc_host(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    fpc_asserts u_fpc_asserts(.pclk(pclk), .presetn(presetn),
        .ctrl_wr(link.ctrl_wr), .ctrl_wdata(link.ctrl_wdata),
        .stat_wr(link.stat_wr), .stat_wdata(link.stat_wdata),
        .dptr_wr(link.dptr_wr), .code_rd(link.code_rd),
        .ctrl_rdata(link.ctrl_rdata), .stat_rdata(link.stat_rdata),
        .code_rvalid(link.code_rvalid));
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (xram_wr) xw <= xw + 1;
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        serr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    // Poll until no command is pending, and no busy if b
    task automatic idle(input logic b);
        apb(1'h0, HOST_STATUS, 32'h0);
        while (q[0] || (b && q[8])) apb(1'h0, HOST_STATUS, 32'h0);
    endtask : idle
    task automatic cmd(input logic [2:0] op, input logic [7:0] arg);
        idle(1'h0);
        apb(1'h1, HOST_CMD, {16'h0, arg, 5'h0, op});
    endtask : cmd
    task automatic ld(input logic [15:0] a, input logic [7:0] d);
        idle(1'h0);
        apb(1'h1, HOST_ADDR, {16'h0, a});
        cmd(3'h3, d);
    endtask : ld
    task automatic code(input logic [15:0] a, input logic [7:0] e);
        idle(1'h0);
        apb(1'h1, HOST_ADDR, {16'h0, a});
        cmd(3'h4, 8'h0);
        idle(1'h0);
        apb(1'h0, HOST_RDATA, 32'h0);
        `CHK(q[7:0], e)
    endtask : code
    // Expected {sequence_error, buffer_loaded} once idle
    task automatic st(input logic [1:0] e);
        idle(1'h1);
        `CHK(q[17:16], e)
    endtask : st
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        end_of_test;
    end
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h1, HOST_MODE, 32'h2);
        cmd(3'h1, 8'h00);
        ld(16'h0200, 8'h99);
        cmd(3'h1, 8'h08);
        ld(16'h0105, 8'h3C);
        ld(16'h0090, 8'h42);
        st(2'h1);
        `CHK(xw, 1)
        `CHK(xram_ext, 1'h1)
        cmd(3'h5, 8'h08);
        st(2'h0);
        code(16'h0085, 8'h3C);
        code(16'h0090, 8'h42);
        code(16'h0105, 8'hFF);
        code(16'h0091, 8'hFF);
        $display("test page write done");
        ld(16'h0300, 8'h11);
        cmd(3'h5, 8'h08);
        apb(1'h1, HOST_CMD, 32'h0000_0001);
        `CHK(serr, 1'h1)
        ld(16'h0301, 8'h22);
        st(2'h0);
        code(16'h0301, 8'hFF);
        $display("test busy buffer done");
        cmd(3'h5, 8'h08);
        st(2'h2);
        cmd(3'h2, 8'h00);
        st(2'h0);
        cmd(3'h1, 8'hA8);
        st(2'h2);
        cmd(3'h2, 8'h00);
        cmd(3'h1, 8'h58);
        ld(16'h0500, 8'h01);
        idle(1'h1);
        `CHK(q[17], 1'h1)
        ld(16'h0400, 8'h55);
        cmd(3'h5, 8'h0E);
        st(2'h0);
        cmd(3'h5, 8'h08);
        st(2'h2);
        cmd(3'h2, 8'h00);
        $display("test sequence errors done");
        ld(16'hFF85, 8'h5A);
        cmd(3'h5, 8'h0A);
        st(2'h0);
        cmd(3'h1, 8'h02);
        code(16'hFF85, 8'h5A);
        apb(1'h1, HOST_MODE, 32'h3);
        code(16'hFF85, 8'hFF);
        apb(1'h1, HOST_MODE, 32'h2);
        cmd(3'h1, 8'h00);
        code(16'hFF85, 8'hFF);
        cmd(3'h1, 8'h0C);
        ld(16'h0000, 8'h7E);
        cmd(3'h5, 8'h0C);
        st(2'h0);
        cmd(3'h1, 8'h04);
        code(16'h0000, 8'h7E);
        $display("test regions done");
        apb(1'h0, 8'h14, 32'h0);
        `CHK(serr, 1'h1)
        `CHK(q, 32'h0)
        end_of_test;
    end
endmodule : fpc_tb
